/* rtl/sort_if_pkg.sv */
// Constants, codes and register layout for the part handler sorting interface
// How it works
// [R1] Comparator outcome appears on the handler connector for automatic part sorting.
// [R2] A rising trigger edge starts a measurement by default.
// [R3] A control bit moves the trigger to the falling edge.
// [R4] Seven inverted select lines form one binary memory number, bit 0 lowest.
// [R5] The select code counts only while the select strobe is low.
// [R6] Handler holds strobe low and code stable at the trigger edge.
// [R7] Handler trigger with valid select recalls that memory, then measures.
// [R8] A memory number beyond the existing memories flags an error instead.
// [R9] One set of result lines serves all modes; mode sets each meaning.
// [R10] Sorting mode shows the class on fourteen active-low class lines.
// [R11] Sorting mode asserts the fail line when no class matches.
// [R12] Limit mode shows primary above, within, below on three lines.
// [R13] Limit mode shows secondary above, within, below on three lines.
// [R14] Limit mode pass line only when both parameters are within limits.
// [R15] Limit mode fail line when either parameter is outside limits.
// [R16] Lines without meaning in limit or zone mode stay high.
// [R17] All slash-named lines are negative logic: asserted means low.
// [R18] Acquisition-done goes low once acquisition ends; part may be swapped.
// [R19] End-of-measurement goes low only when results are valid; the code also drives it low on a range error or measurement fault.
// [R20] While the error line is asserted all result lines are suppressed.
// [R21] Result lines are registered and held until the next results.
package sort_if_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int MEM_W = 7;
  localparam int BIN_N = 14;
  localparam int LINE_N = 15;
  localparam int CNT_W = 16;

  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_MEMCNT = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_TRIGCNT = 4'hc;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FALL_BIT = 2;
  localparam int CTRL_HANDLER_BIT = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h8;
  localparam logic [7:0] MEMCNT_RST = 8'h40;

  localparam int ST_LSB = 0;
  localparam int ST_ERR_BIT = 3;
  localparam int ST_ACQ_BIT = 4;
  localparam int ST_EOM_BIT = 5;
  localparam int ST_MEM_LSB = 8;
  localparam int ST_RECALL_BIT = 15;

  // Result line positions for limit and zone modes; only LN_FAIL is shared by all modes
  localparam int LN_P1 = 0;
  localparam int LN_S1 = 3;
  localparam int LN_PASS = 6;
  localparam int LN_NA = 8;
  localparam int LN_FAIL = 14;

  typedef enum logic [1:0] {
    MODE_BIN = 2'h0,
    MODE_LIMIT = 2'h1,
    MODE_ZONE = 2'h2
  } cmpMode_t;

  typedef enum logic [1:0] {
    CMP_IN = 2'h0,
    CMP_ABOVE = 2'h1,
    CMP_BELOW = 2'h2,
    CMP_NA = 2'h3
  } cmpCode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RECALL = 3'h2,
    ST_MEAS = 3'h4
  } state_t;

endpackage

/* rtl/part_handler_sort_interface.sv */
// Handler connector logic: trigger, memory recall, result lines, Avalon-MM registers
`timescale 1ns/10ps
module part_handler_sort_interface #(
  parameter int MEM_MAX = 128
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_start_edge,
  input wire logic [6:0] mem_sel_bit_n,
  input wire logic mem_sel_strobe_n,
  input wire logic acqDone,
  input wire logic measDone,
  input wire logic measFault,
  input wire logic [3:0] binHit,
  input wire logic [1:0] primCmp,
  input wire logic [1:0] secCmp,
  output logic recallStrobe,
  output logic [6:0] recallMem,
  output logic measStart,
  output logic [13:0] sort_class_n,
  output logic no_class_fail_n,
  output logic acq_done_n,
  output logic result_valid_n,
  output logic meas_error_n
);

  generate
    if (MEM_MAX < 1 || MEM_MAX > 128) begin : badMemMax
      $error("MEM_MAX must lie in 1..128");
    end
  endgenerate

  sort_if_pkg::state_t state_q, state_d;
  logic [3:0] ctrl_q, ctrl_d;
  logic [7:0] memCnt_q, memCnt_d;
  logic [15:0] trigCnt_q, trigCnt_d;
  logic trigPrev_q;
  logic [14:0] lines_q, lines_d;
  logic acqN_q, acqN_d, eomN_q, eomN_d, errN_q, errN_d;
  logic recStb_q, recStb_d, start_q, start_d;
  logic [6:0] recMem_q, recMem_d;
  logic lastRecall_q, lastRecall_d;
  logic waitReq_q, waitReq_d;
  logic [31:0] rdata_q, rdata_d;

  logic trigEdge, busAccept;
  logic [6:0] memSel;
  logic [13:0] binOn;
  logic [14:0] lineOn;
  logic primIn, secIn, cmpPass;
  sort_if_pkg::cmpMode_t mode;

  assign mode = sort_if_pkg::cmpMode_t'(ctrl_q[sort_if_pkg::CTRL_MODE_LSB +: 2]);
  // Edge polarity chosen by control bit
  assign trigEdge = ctrl_q[sort_if_pkg::CTRL_FALL_BIT] ? (trigPrev_q & ~ext_start_edge) // R3
                                                      : (~trigPrev_q & ext_start_edge); // R2
  assign memSel = ~mem_sel_bit_n; // R4 R17
  assign busAccept = ~waitReq_q;

  genvar gi;
  generate
    for (gi = 0; gi < sort_if_pkg::BIN_N; gi++) begin : binDecode
      assign binOn[gi] = (binHit == 4'(gi + 1)); // R10
    end
  endgenerate

  assign primIn = (primCmp == sort_if_pkg::CMP_IN);
  assign secIn = (secCmp == sort_if_pkg::CMP_IN);
  assign cmpPass = primIn & secIn;

  // Meaning of each result line per comparator mode
  always_comb begin
    lineOn = '0; // R16
    unique case (mode) // R9
      sort_if_pkg::MODE_LIMIT: begin
        lineOn[sort_if_pkg::LN_P1] = (primCmp == sort_if_pkg::CMP_ABOVE); // R12
        lineOn[sort_if_pkg::LN_P1 + 1] = primIn; // R12
        lineOn[sort_if_pkg::LN_P1 + 2] = (primCmp == sort_if_pkg::CMP_BELOW); // R12
        lineOn[sort_if_pkg::LN_S1] = (secCmp == sort_if_pkg::CMP_ABOVE); // R13
        lineOn[sort_if_pkg::LN_S1 + 1] = secIn; // R13
        lineOn[sort_if_pkg::LN_S1 + 2] = (secCmp == sort_if_pkg::CMP_BELOW); // R13
        lineOn[sort_if_pkg::LN_PASS] = cmpPass; // R14
        lineOn[sort_if_pkg::LN_FAIL] = ~cmpPass; // R15
      end
      sort_if_pkg::MODE_ZONE: begin
        lineOn[sort_if_pkg::LN_P1] = primCmp == sort_if_pkg::CMP_ABOVE || primCmp == sort_if_pkg::CMP_BELOW;
        lineOn[sort_if_pkg::LN_P1 + 1] = primIn;
        lineOn[sort_if_pkg::LN_P1 + 2] = (primCmp == sort_if_pkg::CMP_NA);
        lineOn[sort_if_pkg::LN_S1] = secCmp == sort_if_pkg::CMP_ABOVE || secCmp == sort_if_pkg::CMP_BELOW;
        lineOn[sort_if_pkg::LN_S1 + 1] = secIn;
        lineOn[sort_if_pkg::LN_S1 + 2] = (secCmp == sort_if_pkg::CMP_NA);
        lineOn[sort_if_pkg::LN_PASS] = cmpPass;
        lineOn[sort_if_pkg::LN_NA] = (primCmp == sort_if_pkg::CMP_NA) || (secCmp == sort_if_pkg::CMP_NA);
        lineOn[sort_if_pkg::LN_FAIL] = lineOn[sort_if_pkg::LN_P1] | lineOn[sort_if_pkg::LN_S1];
      end
      default: begin
        lineOn[13:0] = binOn; // R10
        lineOn[sort_if_pkg::LN_FAIL] = ~|binOn; // R11
      end
    endcase
  end

  // Trigger, recall and measurement sequencing
  always_comb begin
    state_d = state_q;
    lines_d = lines_q;
    acqN_d = acqN_q;
    eomN_d = eomN_q;
    errN_d = errN_q;
    recStb_d = 1'b0;
    start_d = 1'b0;
    recMem_d = recMem_q;
    lastRecall_d = lastRecall_q;
    trigCnt_d = trigCnt_q;
    unique case (state_q)
      sort_if_pkg::ST_IDLE: begin
        if (trigEdge && ctrl_q[sort_if_pkg::CTRL_HANDLER_BIT]) begin
          trigCnt_d = trigCnt_q + 16'h0001;
          acqN_d = 1'b1;
          eomN_d = 1'b1;
          errN_d = 1'b1;
          lastRecall_d = ~mem_sel_strobe_n;
          if (!mem_sel_strobe_n) begin // R5 R6
            recMem_d = memSel;
            if ({1'b0, memSel} >= memCnt_q) begin // R8
              errN_d = 1'b0;
              eomN_d = 1'b0;
              lines_d = '1; // R20
            end else begin
              recStb_d = 1'b1; // R7
              state_d = sort_if_pkg::ST_RECALL;
            end
          end else begin
            start_d = 1'b1; // R2
            state_d = sort_if_pkg::ST_MEAS;
          end
        end
      end
      sort_if_pkg::ST_RECALL: begin
        start_d = 1'b1; // R7
        state_d = sort_if_pkg::ST_MEAS;
      end
      sort_if_pkg::ST_MEAS: begin
        if (measFault) begin
          errN_d = 1'b0;
          eomN_d = 1'b0;
          acqN_d = 1'b0;
          lines_d = '1; // R20
          state_d = sort_if_pkg::ST_IDLE;
        end else begin
          if (acqDone) begin
            acqN_d = 1'b0; // R18
          end
          if (measDone) begin
            lines_d = ~lineOn; // R1 R17 R21
            acqN_d = 1'b0;
            eomN_d = 1'b0; // R19
            state_d = sort_if_pkg::ST_IDLE;
          end
        end
      end
      default: state_d = sort_if_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= sort_if_pkg::ST_IDLE;
      lines_q <= '1;
      acqN_q <= 1'b1;
      eomN_q <= 1'b1;
      errN_q <= 1'b1;
      recStb_q <= 1'b0;
      start_q <= 1'b0;
      recMem_q <= 7'h00;
      lastRecall_q <= 1'b0;
      trigCnt_q <= 16'h0000;
      trigPrev_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      lines_q <= lines_d;
      acqN_q <= acqN_d;
      eomN_q <= eomN_d;
      errN_q <= errN_d;
      recStb_q <= recStb_d;
      start_q <= start_d;
      recMem_q <= recMem_d;
      lastRecall_q <= lastRecall_d;
      trigCnt_q <= trigCnt_d;
      trigPrev_q <= ext_start_edge;
    end
  end

  // Avalon-MM slave: one wait cycle, then a one-cycle answer
  always_comb begin
    waitReq_d = 1'b1;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    memCnt_d = memCnt_q;
    if ((avs_read || avs_write) && waitReq_q) begin
      waitReq_d = 1'b0;
      rdata_d = 32'h0000_0000;
      unique case (avs_address)
        sort_if_pkg::OFS_CTRL: rdata_d[3:0] = ctrl_q;
        sort_if_pkg::OFS_MEMCNT: rdata_d[7:0] = memCnt_q;
        sort_if_pkg::OFS_STATUS: begin
          rdata_d[sort_if_pkg::ST_LSB +: 3] = state_q;
          rdata_d[sort_if_pkg::ST_ERR_BIT] = ~errN_q;
          rdata_d[sort_if_pkg::ST_ACQ_BIT] = ~acqN_q;
          rdata_d[sort_if_pkg::ST_EOM_BIT] = ~eomN_q;
          rdata_d[sort_if_pkg::ST_MEM_LSB +: 7] = recMem_q;
          rdata_d[sort_if_pkg::ST_RECALL_BIT] = lastRecall_q;
        end
        sort_if_pkg::OFS_TRIGCNT: rdata_d[15:0] = trigCnt_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (avs_write && busAccept && avs_byteenable[0]) begin
      if (avs_address == sort_if_pkg::OFS_CTRL) begin
        ctrl_d = avs_writedata[3:0];
      end
      if (avs_address == sort_if_pkg::OFS_MEMCNT) begin
        // Clamp to the memories that exist
        memCnt_d = (avs_writedata[7:0] > 8'(MEM_MAX)) ? 8'(MEM_MAX) : avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      waitReq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= sort_if_pkg::CTRL_RST;
      memCnt_q <= sort_if_pkg::MEMCNT_RST;
    end else if (clkEn) begin
      waitReq_q <= waitReq_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      memCnt_q <= memCnt_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitReq_q;
  assign recallStrobe = recStb_q;
  assign recallMem = recMem_q;
  assign measStart = start_q;
  assign sort_class_n = lines_q[13:0];
  assign no_class_fail_n = lines_q[sort_if_pkg::LN_FAIL];
  assign acq_done_n = acqN_q;
  assign result_valid_n = eomN_q;
  assign meas_error_n = errN_q;

endmodule // part_handler_sort_interface

/* verif/handler_model.sv */
// Part handler model driving trigger and memory select lines
`timescale 1ns/10ps
module handler_model (
  input wire logic sys_clk,
  output logic ext_start_edge = 1'b0,
  output logic [6:0] mem_sel_bit_n = 7'h55,
  output logic mem_sel_strobe_n = 1'b1
);
  logic selOn = 1'b0;
  logic [6:0] selCode = 7'h00;
  // Released select lines change every cycle
  always @(posedge sys_clk) begin
    mem_sel_strobe_n <= ~selOn;
    mem_sel_bit_n <= selOn ? ~selCode : ~mem_sel_bit_n;
  end
  task automatic fire(input logic [6:0] code, input logic sel);
    @(posedge sys_clk);
    selCode <= code;
    selOn <= sel;
    repeat (2) @(posedge sys_clk);
    ext_start_edge <= ~ext_start_edge;
    @(posedge sys_clk);
    selOn <= 1'b0;
  endtask
endmodule // handler_model

/* verif/part_handler_sort_interface_properties.sv */
// Port checker for the handler sorting interface
`timescale 1ns/10ps
module sort_if_checker (
  input logic sys_clk,
  input logic sys_rst,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic ext_start_edge,
  input logic [6:0] mem_sel_bit_n,
  input logic mem_sel_strobe_n,
  input logic measDone,
  input logic recallStrobe,
  input logic [6:0] recallMem,
  input logic measStart,
  input logic [13:0] sort_class_n,
  input logic no_class_fail_n,
  input logic acq_done_n,
  input logic result_valid_n,
  input logic meas_error_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  AST_RST_IDLE: assert property ($fell(sys_rst) |-> avs_waitrequest &&
    &{sort_class_n, no_class_fail_n, acq_done_n, result_valid_n, meas_error_n}) else $error("idle lost");
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  AST_RECALL_SEL: assert property (recallStrobe |-> recallMem == ~$past(mem_sel_bit_n) &&
    !$past(mem_sel_strobe_n) && $past(ext_start_edge) != $past(ext_start_edge, 2)) else $error("bad recall");
  AST_START_AFTER: assert property (recallStrobe |=> measStart) else $error("no start");
  AST_START_CAUSE: assert property (measStart |-> $past(recallStrobe) ||
    $past(ext_start_edge) != $past(ext_start_edge, 2)) else $error("stray start");
  AST_ERR_QUIET: assert property (!meas_error_n |-> sort_class_n == 14'h3fff && no_class_fail_n)
    else $error("lines during error");
  AST_EOM_CAUSE: assert property ($fell(result_valid_n) && meas_error_n |-> $past(measDone))
    else $error("early valid");
  // An out-of-range trigger while results stand keeps the valid line low but blanks the lines
  AST_HOLD: assert property (!result_valid_n && !$past(result_valid_n) && $stable(meas_error_n) |->
    $stable(sort_class_n) &&
    $stable(no_class_fail_n)) else $error("lines moved");
endmodule // sort_if_checker
bind part_handler_sort_interface sort_if_checker sort_if_checker_i (.sys_clk, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .ext_start_edge, .mem_sel_bit_n, .mem_sel_strobe_n, .measDone, .recallStrobe, .recallMem,
  .measStart, .sort_class_n, .no_class_fail_n, .acq_done_n, .result_valid_n, .meas_error_n);

/* verif/part_handler_sort_interface_tb_top.sv */
// Self-checking bench for the part handler sorting interface
`timescale 1ns/10ps
module part_handler_sort_interface_tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic avs_read = 1'b0, avs_write = 1'b0, acqDone = 1'b0, measDone = 1'b0, measFault = 1'b0;
  logic [3:0] avs_address = 4'h0, binHit = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [1:0] primCmp = 2'h0, secCmp = 2'h0;
  logic [6:0] mem_sel_bit_n, recallMem;
  logic [13:0] sort_class_n;
  logic avs_waitrequest, ext_start_edge, mem_sel_strobe_n, recallStrobe, measStart;
  logic no_class_fail_n, acq_done_n, result_valid_n, meas_error_n;
  int fails = 0, cmp_count = 0, cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  part_handler_sort_interface part_handler_sort_interface_i (.sys_clk, .sys_rst, .clkEn(1'b1), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .ext_start_edge,
    .mem_sel_bit_n, .mem_sel_strobe_n, .acqDone, .measDone, .measFault, .binHit, .primCmp, .secCmp, .recallStrobe,
    .recallMem, .measStart, .sort_class_n, .no_class_fail_n, .acq_done_n, .result_valid_n, .meas_error_n);
  handler_model handler_model_i (.sys_clk, .ext_start_edge, .mem_sel_bit_n, .mem_sel_strobe_n);
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic regRw(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic expectIdle();
    repeat (4) begin
      @(posedge sys_clk);
      check("ignored edge", {recallStrobe, measStart}, 2'b00);
    end
  endtask
  // Entry: code, strobe, class, primary, secondary, expected lines
  task automatic measure(input logic [30:0] e, input logic flt);
    logic rc;
    rc = 1'b0;
    handler_model_i.fire(e[30:24], e[23]);
    repeat (4) begin
      @(posedge sys_clk);
      if (recallStrobe === 1'b1) begin
        rc = 1'b1;
        check("recall mem", recallMem, e[30:24]);
      end
      if (measStart === 1'b1)
        break;
    end
    check("recall", rc, e[23]);
    check("start", measStart, 1'b1);
    acqDone <= 1'b1;
    @(posedge sys_clk);
    acqDone <= 1'b0;
    @(posedge sys_clk);
    check("acq", {acq_done_n, result_valid_n}, 2'b01);
    {binHit, primCmp, secCmp} <= e[22:15];
    measDone <= 1'b1;
    measFault <= flt;
    @(posedge sys_clk);
    measDone <= 1'b0;
    measFault <= 1'b0;
    @(posedge sys_clk);
    check("lines", {no_class_fail_n, sort_class_n}, e[14:0]);
    check("eom err", {result_valid_n, meas_error_n}, {1'b0, ~flt});
  endtask
  task automatic seq(input logic [30:0] e);
    measure(e, 1'b0);
    handler_model_i.fire(7'h00, 1'b0);
    expectIdle();
  endtask
  task automatic t_reset();
    logic [31:0] rd;
    @(posedge sys_clk);
    check("idle", {no_class_fail_n, sort_class_n, acq_done_n, result_valid_n, meas_error_n}, 18'h3ffff);
    regRw(1'b0, sort_if_pkg::OFS_CTRL, 32'h0, rd);
    check("ctrl", rd, sort_if_pkg::CTRL_RST);
    regRw(1'b0, sort_if_pkg::OFS_MEMCNT, 32'h0, rd);
    check("memcnt", rd, sort_if_pkg::MEMCNT_RST);
    regRw(1'b1, 4'h2, 32'h5, rd);
    regRw(1'b0, 4'h2, 32'h0, rd);
    check("unmapped", rd, 32'h0);
  endtask
  task automatic t_bin();
    logic [30:0] tbl [3];
    tbl = '{{7'h05, 1'b1, 4'h3, 4'h0, 15'h7ffb}, {7'h00, 1'b0, 4'h0, 4'h0, 15'h3fff},
      {7'h2a, 1'b1, 4'he, 4'h0, 15'h5fff}};
    foreach (tbl[i])
      seq(tbl[i]);
  endtask
  task automatic t_limit();
    logic [30:0] tbl [3];
    logic [31:0] rd;
    tbl = '{{7'h01, 1'b1, 4'h0, 4'h0, 15'h7fad}, {7'h02, 1'b1, 4'h0, 4'h4, 15'h3fee},
      {7'h3f, 1'b1, 4'h0, 4'h2, 15'h3fdd}};
    regRw(1'b1, sort_if_pkg::OFS_CTRL, 32'h9, rd);
    foreach (tbl[i])
      seq(tbl[i]);
    regRw(1'b1, sort_if_pkg::OFS_CTRL, 32'ha, rd);
    seq({7'h10, 1'b1, 4'h0, 4'h0, 15'h7fad});
  endtask
  task automatic t_fall();
    logic [31:0] rd;
    regRw(1'b1, sort_if_pkg::OFS_CTRL, 32'hc, rd);
    handler_model_i.fire(7'h03, 1'b1);
    expectIdle();
    measure({7'h00, 1'b1, 4'h1, 4'h0, 15'h7ffe}, 1'b0);
    regRw(1'b1, sort_if_pkg::OFS_CTRL, 32'h0, rd);
    repeat (2) begin
      handler_model_i.fire(7'h01, 1'b1);
      expectIdle();
    end
  endtask
  task automatic t_range();
    logic [31:0] rd;
    regRw(1'b1, sort_if_pkg::OFS_CTRL, 32'h8, rd);
    regRw(1'b1, sort_if_pkg::OFS_MEMCNT, 32'h4, rd);
    handler_model_i.fire(7'h04, 1'b1);
    @(posedge sys_clk);
    check("range", {recallStrobe, meas_error_n, result_valid_n, no_class_fail_n, sort_class_n}, 18'h07fff);
    handler_model_i.fire(7'h00, 1'b0);
    expectIdle();
    measure({7'h03, 1'b1, 4'h3, 4'h0, 15'h7fff}, 1'b1);
    regRw(1'b0, sort_if_pkg::OFS_STATUS, 32'h0, rd);
    check("status", rd, 32'h0000_8339);
    regRw(1'b0, sort_if_pkg::OFS_TRIGCNT, 32'h0, rd);
    check("trigcnt", rd, 32'h0000_000a);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_bin();
    t_limit();
    t_fall();
    t_range();
    complete_run();
  end
endmodule // part_handler_sort_interface_tb_top
